// ==== pkg/mmi_defs.svh ====
// Opcodes, addresses, reset values and timing counts of the executor.
`ifndef MMI_DEFS_SVH
`define MMI_DEFS_SVH

`define MMI_OPC_MOVE_SRC 4'hc
`define MMI_OPC_MOVE_DST 4'hf
`define MMI_OPC_BANK 8'h01
`define MMI_OPC_LITW 8'h0e
`define MMI_OPC_MUL 8'h0d
`define MMI_OPC_STORE 7'h37

`define MMI_WREG_ADDR 12'hfe8
`define MMI_PCLOW_ADDR 12'hff9
`define MMI_TOSUP_ADDR 12'hfff
`define MMI_TOSHI_ADDR 12'hffe
`define MMI_TOSLO_ADDR 12'hffd
`define MMI_ACCESS_SPLIT 8'h80
`define MMI_ACCESS_HI_BANK 4'hf
`define MMI_ACCESS_LO_BANK 4'h0

`define MMI_W_RST 8'h00
`define MMI_BANK_RST 8'h00
`define MMI_PROD_RST 8'h00
`define MMI_IR_RST 16'h0000
`define MMI_ADDR_RST 12'h000

`define MMI_CLK_MHZ 200
`define MMI_QUARTER_NS 20
`define MMI_QUARTER_CYC ((`MMI_QUARTER_NS * `MMI_CLK_MHZ + 999) / 1000)

`endif

// ==== pkg/mmi_pkg.sv ====
// Types shared by the executor modules.
package mmi_pkg;

   // Quarter phases of one instruction cycle.
   typedef enum logic [3:0]
   {
      QP_1 = 4'b0001,
      QP_2 = 4'b0010,
      QP_3 = 4'b0100,
      QP_4 = 4'b1000
   } mmi_phase_e;

   // Instruction being executed in the current instruction cycle.
   typedef enum logic [6:0]
   {
      OP_NONE  = 7'b0000001,
      OP_MOVE1 = 7'b0000010,
      OP_MOVE2 = 7'b0000100,
      OP_BANK  = 7'b0001000,
      OP_LITW  = 7'b0010000,
      OP_STORE = 7'b0100000,
      OP_MUL   = 7'b1000000
   } mmi_op_e;

endpackage

// ==== rtl/mmi_qphase.sv ====
// Quarter-phase generator: divides mclk and walks Q1 to Q4.
`timescale 1ns/1ps
`include "mmi_defs.svh"

module mmi_qphase
   import mmi_pkg::*;
(
   input wire logic mclk, // System clock.
   input wire logic resetn, // Asynchronous reset, active low.
   output logic qTick, // Pulse on the last clock of a quarter.
   output mmi_phase_e qPhase // Current quarter phase.
);

   localparam int QCYC = `MMI_QUARTER_CYC;
   localparam logic [7:0] QLAST = 8'(QCYC - 1);

   logic [7:0] divCnt;
   logic [7:0] next_divCnt;
   logic next_qTick;
   mmi_phase_e next_qPhase;

   // The tick is registered so it lines up with the last clock of a quarter.
   always_comb
   begin
      next_qTick = 1'b0;
      next_divCnt = divCnt + 8'h01;
      next_qPhase = qPhase;
      if (divCnt == QLAST)
      begin
         next_divCnt = 8'h00;
      end
      if (next_divCnt == QLAST)
      begin
         next_qTick = 1'b1;
      end
      if (qTick)
      begin
         unique case (qPhase)
            QP_1: next_qPhase = QP_2;
            QP_2: next_qPhase = QP_3;
            QP_3: next_qPhase = QP_4;
            QP_4: next_qPhase = QP_1;
            default: next_qPhase = QP_1;
         endcase
      end
   end

   // Divider and phase registers.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         divCnt <= 8'h00;
         qTick <= 1'b0;
         qPhase <= QP_1;
      end
      else
      begin
         divCnt <= next_divCnt;
         qTick <= next_qTick;
         qPhase <= next_qPhase;
      end
   end

endmodule

// ==== rtl/mmi_exec.sv ====
// Executor for moves, literal loads and literal multiply of an 8-bit core.
// Behaviour
// - Two-word move: first word 1100 plus source, second 1111 plus dest.
// - Move source and destination are full 12-bit addresses, no bank.
// - Move copies byte unchanged; working register addressable; no flags.
// - Move takes two words, reads in first cycle, writes in second.
// - Opcode 0000 0001 with literal loads bank select in one cycle.
// - Bank literal latched on the last clock of Q1, written in fourth quarter.
// - Opcode 0000 1110 loads literal into working register, no flags.
// - Literal multiply gives unsigned 16-bit product, high and low bytes.
// - Multiply keeps working register and flags; zero is not flagged.
// - Access-select one uses bank select, zero uses the access bank.
`timescale 1ns/1ps
`include "mmi_defs.svh"

module mmi_exec
   import mmi_pkg::*;
(
   input wire logic mclk, // System clock, 200 MHz.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic [15:0] instrWord, // Program word, stable during Q1.
   input wire logic [7:0] memRdata, // Data memory read data.
   output mmi_phase_e qPhase, // Current quarter phase.
   output logic [11:0] memAddr, // Data memory address.
   output logic memRd, // Data memory read strobe, high in Q2.
   output logic memWr, // Data memory write strobe, high in Q4.
   output logic [7:0] memWdata, // Data memory write data.
   output logic [7:0] wReg, // Working register.
   output logic [7:0] bankSelect, // Bank select register.
   output logic [7:0] productHigh, // Product high byte.
   output logic [7:0] productLow // Product low byte.
);

   logic qTick;
   mmi_op_e op;
   mmi_op_e next_op;
   logic [15:0] ir;
   logic [15:0] next_ir;
   logic [7:0] hold;
   logic [7:0] next_hold;
   logic [11:0] next_memAddr;
   logic next_memRd;
   logic next_memWr;
   logic [7:0] next_memWdata;
   logic [7:0] next_wReg;
   logic [7:0] next_bankSelect;
   logic [7:0] next_productHigh;
   logic [7:0] next_productLow;
   logic [15:0] product;

   // Quarter phases come from a divider so one instruction cycle is 4 quarters.
   mmi_qphase u_qphase
   (
      .mclk(mclk),
      .resetn(resetn),
      .qTick(qTick),
      .qPhase(qPhase)
   );

   // Classifies a program word; a pending move expects its second word.
   function automatic mmi_op_e decode(input logic [15:0] w, input logic pend);
      mmi_op_e r;
      r = OP_NONE;
      if (pend && w[15:12] == `MMI_OPC_MOVE_DST)
         r = OP_MOVE2;
      else if (w[15:12] == `MMI_OPC_MOVE_SRC)
         r = OP_MOVE1;
      else if (w[15:8] == `MMI_OPC_BANK)
         r = OP_BANK;
      else if (w[15:8] == `MMI_OPC_LITW)
         r = OP_LITW;
      else if (w[15:8] == `MMI_OPC_MUL)
         r = OP_MUL;
      else if (w[15:9] == `MMI_OPC_STORE)
         r = OP_STORE;
      return r;
   endfunction

   // Banked address of an 8-bit file operand with its access-select bit.
   function automatic logic [11:0] fileAddr(input logic a,
      input logic [7:0] f, input logic [7:0] bsel);
      logic [11:0] r;
      if (a)
         r = {bsel[3:0], f};
      else if (f < `MMI_ACCESS_SPLIT)
         r = {`MMI_ACCESS_LO_BANK, f};
      else
         r = {`MMI_ACCESS_HI_BANK, f};
      return r;
   endfunction

   // True where the address is the working register itself.
   function automatic logic isWork(input logic [11:0] addr);
      return addr == `MMI_WREG_ADDR;
   endfunction

   // Destinations the move cannot write; such a write is simply dropped.
   function automatic logic noMoveDest(input logic [11:0] addr);
      return addr == `MMI_PCLOW_ADDR || addr == `MMI_TOSUP_ADDR ||
         addr == `MMI_TOSHI_ADDR || addr == `MMI_TOSLO_ADDR;
   endfunction

   // Plain unsigned 8 by 8 multiply; overflow is impossible in 16 bits.
   assign product = 16'(wReg) * 16'(ir[7:0]);

   // Next-state logic; every action happens on the last clock of a quarter.
   always_comb
   begin
      next_op = op;
      next_ir = ir;
      next_hold = hold;
      next_memAddr = memAddr;
      next_memRd = memRd;
      next_memWr = memWr;
      next_memWdata = memWdata;
      next_wReg = wReg;
      next_bankSelect = bankSelect;
      next_productHigh = productHigh;
      next_productLow = productLow;
      if (qTick)
      begin
         unique case (qPhase)
            QP_1:
            begin
               // Decode; a move source read is set up for Q2.
               next_ir = instrWord;
               next_op = decode(instrWord, op == OP_MOVE1);
               if (next_op == OP_MOVE1)
               begin
                  next_memAddr = instrWord[11:0];
                  next_memRd = !isWork(instrWord[11:0]);
               end
            end
            QP_2:
            begin
               // Capture the source byte; the working register reads inside.
               next_memRd = 1'b0;
               if (op == OP_MOVE1)
               begin
                  next_hold = isWork(ir[11:0]) ? wReg : memRdata;
               end
            end
            QP_3:
            begin
               // Set up the Q4 write; the second move cycle reads nothing.
               if (op == OP_MOVE2 && !isWork(ir[11:0]) &&
                  !noMoveDest(ir[11:0]))
               begin
                  next_memAddr = ir[11:0];
                  next_memWdata = hold;
                  next_memWr = 1'b1;
               end
               else if (op == OP_STORE &&
                  !isWork(fileAddr(ir[8], ir[7:0], bankSelect)))
               begin
                  next_memAddr = fileAddr(ir[8], ir[7:0], bankSelect);
                  next_memWdata = wReg;
                  next_memWr = 1'b1;
               end
            end
            QP_4:
            begin
               // Register writes land at the end of Q4; flags are untouched.
               next_memWr = 1'b0;
               unique case (op)
                  OP_BANK: next_bankSelect = ir[7:0];
                  OP_LITW: next_wReg = ir[7:0];
                  OP_MUL:
                  begin
                     next_productHigh = product[15:8];
                     next_productLow = product[7:0];
                  end
                  OP_MOVE2:
                  begin
                     if (isWork(ir[11:0]))
                        next_wReg = hold;
                  end
                  OP_NONE, OP_MOVE1, OP_STORE:
                  begin
                  end
               endcase
            end
            default:
            begin
            end
         endcase
      end
   end

   // Executor registers.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         op <= OP_NONE;
         ir <= `MMI_IR_RST;
         hold <= `MMI_W_RST;
         memAddr <= `MMI_ADDR_RST;
         memRd <= 1'b0;
         memWr <= 1'b0;
         memWdata <= `MMI_W_RST;
         wReg <= `MMI_W_RST;
         bankSelect <= `MMI_BANK_RST;
         productHigh <= `MMI_PROD_RST;
         productLow <= `MMI_PROD_RST;
      end
      else
      begin
         op <= next_op;
         ir <= next_ir;
         hold <= next_hold;
         memAddr <= next_memAddr;
         memRd <= next_memRd;
         memWr <= next_memWr;
         memWdata <= next_memWdata;
         wReg <= next_wReg;
         bankSelect <= next_bankSelect;
         productHigh <= next_productHigh;
         productLow <= next_productLow;
      end
   end

endmodule

// ==== testbench/mmi_exec_monitor.sv ====
// Checker of strobe timing and register update moments of the executor.
`timescale 1ns/1ps
`include "mmi_defs.svh"
module mmi_exec_monitor
   import mmi_pkg::*;
(
   input wire logic mclk, // Clock.
   input wire logic resetn, // Reset, active low.
   input wire logic [3:0] qPhase, // Quarter phase, one-hot.
   input wire logic memRd, // Read strobe.
   input wire logic memWr, // Write strobe.
   input wire logic [11:0] memAddr, // Address.
   input wire logic [7:0] memWdata, // Write data.
   input wire logic [7:0] wReg, // Working register.
   input wire logic [7:0] bankSelect, // Bank select.
   input wire logic [7:0] productHigh, // Product high.
   input wire logic [7:0] productLow // Product low.
);
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_rdq;
      memRd |-> qPhase == QP_2;
   endproperty
   a_rdq: assert property (p_rdq) else $error("Read out of Q2.");
   property p_wrq;
      memWr |-> qPhase == QP_4;
   endproperty
   a_wrq: assert property (p_wrq) else $error("Write out of Q4.");
   property p_rdlen;
      $rose(memRd) |-> memRd [*4] ##1 !memRd;
   endproperty
   a_rdlen: assert property (p_rdlen) else $error("Bad read.");
   property p_wrlen;
      $rose(memWr) |-> memWr [*4] ##1 !memWr;
   endproperty
   a_wrlen: assert property (p_wrlen) else $error("Bad write.");
   property p_wrhold;
      memWr && $past(memWr) |-> $stable(memAddr) && $stable(memWdata);
   endproperty
   a_wrhold: assert property (p_wrhold) else $error("Write moved.");
   property p_wnotw;
      memWr |-> memAddr != `MMI_WREG_ADDR;
   endproperty
   a_wnotw: assert property (p_wnotw) else $error("Write to W.");
   // Registers may only change as Q4 hands over to the next Q1.
   property p_upd;
      !$stable({wReg, bankSelect, productHigh, productLow}) |->
         $past(qPhase) == QP_4 && qPhase == QP_1;
   endproperty
   a_upd: assert property (p_upd) else $error("Late update.");
   property p_phase;
      !$stable(qPhase) |->
         qPhase == ($past(qPhase) << 1 | $past(qPhase) >> 3);
   endproperty
   a_phase: assert property (p_phase) else $error("Phase skip.");
endmodule

// ==== testbench/mmi_exec_tb.sv ====
// Random and corner test of the move, load and multiply executor.
`timescale 1ns/1ps
`include "mmi_defs.svh"
module mmi_exec_tb;
   import mmi_pkg::*;
   logic mclk, resetn, memRd, memWr;
   logic [15:0] instrWord;
   logic [7:0] memRdata, memWdata, wReg, bankSelect, productHigh;
   logic [7:0] productLow, eW, eB, eH, eL, eD, k, d, wrD;
   logic [11:0] memAddr, wrA, rdA, eA, s, t;
   mmi_phase_e qPhase;
   int fails, checked, seed, wrN, rdN, n0, r0, ew, er, op, i;
   mmi_exec dut_u (.mclk(mclk), .resetn(resetn), .instrWord(instrWord),
      .memRdata(memRdata), .qPhase(qPhase), .memAddr(memAddr),
      .memRd(memRd), .memWr(memWr), .memWdata(memWdata), .wReg(wReg),
      .bankSelect(bankSelect), .productHigh(productHigh),
      .productLow(productLow));
   // Free-running 200 MHz clock.
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Count strobe clocks, so a short or long strobe shows in the count.
   always @(posedge mclk)
   begin
      if (memWr === 1'b1)
      begin
         wrN <= wrN + 1;
         wrA <= memAddr;
         wrD <= memWdata;
      end
      if (memRd === 1'b1)
      begin
         rdN <= rdN + 1;
         rdA <= memAddr;
      end
   end
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Present a word from the first clock of Q1; returns half a clock later.
   task automatic cyc(input logic [15:0] w, input logic [7:0] rd);
      int c;
      c = 0;
      while (c < 4)
      begin
         @(negedge mclk);
         c = (qPhase === QP_4) ? c + 1 : 0;
      end
      @(posedge mclk);
      instrWord <= w;
      memRdata <= rd;
      @(negedge mclk);
   endtask
   // Store address: access bank halves when the select bit is clear.
   function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
      if (a)
         return {eB[3:0], f};
      if (f < `MMI_ACCESS_SPLIT)
         return {`MMI_ACCESS_LO_BANK, f};
      return {`MMI_ACCESS_HI_BANK, f};
   endfunction
   task automatic close_out();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // A hang counts as a mismatch.
   initial
   begin
      #100000;
      fails++;
      close_out();
   end
   // Each instruction is followed by a no-op, then results are compared.
   initial
   begin
      seed = 32'h3faa;
      fails = 0;
      checked = 0;
      eW = 8'h00;
      eB = 8'h00;
      eH = 8'h00;
      eL = 8'h00;
      resetn = 1'b0;
      instrWord = 16'h0000;
      memRdata = 8'h00;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      for (i = 0; i < 60; i++)
      begin
         k = (i < 6) ? 8'hff : 8'($random(seed));
         op = (i < 6) ? i : {$random(seed)} % 6;
         d = 8'($random(seed));
         s = k[5] ? 12'($random(seed)) : `MMI_WREG_ADDR;
         t = {k[7:4], d};
         // The working register and destinations right beside the forbidden bytes are corner cases.
         case (k[3:1])
            3'h1: t = `MMI_WREG_ADDR;
            3'h2: t = 12'hff8;
            3'h3: t = 12'hffc;
            default: ;
         endcase
         // Software never names the unwritable bytes as a move target.
         if (t inside {`MMI_PCLOW_ADDR, `MMI_TOSUP_ADDR, `MMI_TOSHI_ADDR,
            `MMI_TOSLO_ADDR})
            t = t ^ 12'h010;
         n0 = wrN;
         r0 = rdN;
         case (op)
            0: cyc({8'h0e, k}, d);
            1: cyc({8'h01, k}, d);
            2: cyc({8'h0d, k}, d);
            3: cyc({7'h37, k[0], d}, d);
            // No interrupt source exists here, so a move never alters one.
            4: cyc({4'hc, s}, d);
            default: cyc({4'hf, t}, d);
         endcase
         if (op == 4)
            cyc({4'hf, t}, ~d);
         cyc(16'h0000, ~d);
         eA = (op == 3) ? ea(k[0], d) : t;
         eD = (op == 3 || s == `MMI_WREG_ADDR) ? eW : d;
         ew = (op == 3 && eA != `MMI_WREG_ADDR) || (op == 4 && !(t inside
            {`MMI_WREG_ADDR, `MMI_PCLOW_ADDR, `MMI_TOSUP_ADDR,
            `MMI_TOSHI_ADDR, `MMI_TOSLO_ADDR})) ? 4 : 0;
         er = (op == 4 && s != `MMI_WREG_ADDR) ? 4 : 0;
         if (op == 0)
            eW = k;
         if (op == 1)
            eB = k;
         if (op == 2)
            {eH, eL} = eW * k;
         if (op == 4 && t == `MMI_WREG_ADDR)
            eW = eD;
         chk({wReg, bankSelect}, {eW, eB});
         chk({productHigh, productLow}, {eH, eL});
         chk(20'(wrN - n0), 20'(ew));
         chk(20'(rdN - r0), 20'(er));
         if (ew > 0)
            chk({wrA, wrD}, {eA, eD});
         if (er > 0)
            chk(20'(rdA), 20'(s));
         $display("test %0d op %0d done", i, op);
      end
      // A second reset in mid-run clears every register.
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (3) @(negedge mclk);
      chk({wReg, bankSelect}, 20'h0);
      chk({productHigh, productLow}, 20'h0);
      @(posedge mclk);
      resetn <= 1'b1;
      cyc({8'h0e, 8'h5a}, 8'h00);
      cyc(16'h0000, 8'h00);
      chk(20'(wReg), 20'h5a);
      $display("test reset done");
      close_out();
   end
endmodule
bind mmi_exec mmi_exec_monitor mon_u (.mclk(mclk), .resetn(resetn),
   .qPhase(qPhase), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
   .memWdata(memWdata), .wReg(wReg), .bankSelect(bankSelect),
   .productHigh(productHigh), .productLow(productLow));
